//--- rtl/agen_pkg.sv
package agen_pkg;

   // Program counter modes
   typedef enum logic [2:0] {
      PC_SEQ,
      PC_REL,
      PC_IMM,
      PC_TABLE,
      PC_PAIR
   } pc_mode_t;

   // Operand address modes
   typedef enum logic [1:0] {
      OP_DIRECT,
      OP_SHORT,
      OP_SPECIAL,
      OP_NONE
   } op_mode_t;

   localparam logic [15:0] PC_RESET        = 16'h0000;
   localparam logic [15:0] TABLE_BASE      = 16'h0040;
   localparam logic [15:0] TABLE_TOP       = 16'h007f;
   localparam logic [7:0]  SHORT_HIGH      = 8'hfe;
   localparam logic [7:0]  SHORT_SPLIT     = 8'h20;
   localparam logic [6:0]  SHORT_TOP_BITS  = 7'h7f;
   localparam logic [7:0]  SPECIAL_HIGH    = 8'hff;
   localparam logic [7:0]  SPECIAL_LOW_END = 8'h1f;
   localparam int          SIGN_BIT        = 7;
   localparam int          IDX_LSB         = 1;
   localparam int          IDX_MSB         = 5;
   localparam logic [2:0]  MAX_LEN         = 3'h4;

   // Byte register numbers
   localparam logic [2:0] REG_X = 3'h0;
   localparam logic [2:0] REG_A = 3'h1;
   localparam logic [2:0] REG_C = 3'h2;
   localparam logic [2:0] REG_B = 3'h3;
   localparam logic [2:0] REG_E = 3'h4;
   localparam logic [2:0] REG_D = 3'h5;
   localparam logic [2:0] REG_L = 3'h6;
   localparam logic [2:0] REG_H = 3'h7;

   // Pair numbers
   localparam logic [1:0] PAIR_AX = 2'h0;
   localparam logic [1:0] PAIR_BC = 2'h1;
   localparam logic [1:0] PAIR_DE = 2'h2;
   localparam logic [1:0] PAIR_HL = 2'h3;

   // Branch request from the decoder
   typedef struct packed {
      logic       valid;
      pc_mode_t   mode;
      logic [2:0] length;
      logic [7:0] branch_displacement;
      logic [15:0] absolute_target;
      logic [7:0] table_call_instr;
      logic [15:0] accum_pair;
   } pc_req_t;

   // Operand request from the decoder
   typedef struct packed {
      logic       valid;
      op_mode_t   mode;
      logic       word;
      logic [15:0] absolute_target;
      logic [7:0] field;
      logic [2:0] reg_field;
      logic [1:0] pair_operand;
   } op_req_t;

   // Operand address to the memory bus
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic        word;
      logic        error;
      logic [7:0]  reg_sel;
      logic [3:0]  pair_sel;
   } op_addr_t;

endpackage : agen_pkg

//--- rtl/branch_target.sv
`timescale 1ns/1ps
module branch_target
   import agen_pkg::*;
(
   // Inputs
   input  logic [15:0] next_pc,
   input  logic [7:0]  disp,
   // Result
   output logic [15:0] target
);

   always_comb begin
      target = next_pc + {{8{disp[SIGN_BIT]}}, disp};
   end

endmodule : branch_target

//--- rtl/cpu_address_generation.sv
`timescale 1ns/1ps
module cpu_address_generation
   import agen_pkg::*;
(
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RESETN,
   // Decoder requests
   input  wire pc_req_t     PC_REQ,
   input  wire op_req_t     OP_REQ,
   // Table read port
   input  wire logic [7:0]  TABLE_DATA,
   output logic             TABLE_READ,
   output logic [15:0]      TABLE_ADDR,
   // Program counter
   output logic [15:0]      PC,
   output logic             PC_BUSY,
   // Operand address
   output op_addr_t         OP_ADDR
);

   typedef enum logic [1:0] {
      ST_RUN,
      ST_TBL_LO,
      ST_TBL_HI
   } tstate_t;

   typedef struct packed {
      tstate_t     st;
      logic [15:0] pc;
      logic [15:0] taddr;
      logic [7:0]  tlo;
      logic        tread;
      logic        busy;
      op_addr_t    op;
   } state_t;

   state_t      s;
   state_t      next_s;
   logic [15:0] seq_pc;
   logic [15:0] rel_pc;
   op_addr_t    op_res;

   function automatic logic [15:0] table_entry(input logic [7:0] opc);
      table_entry = TABLE_BASE + {10'h000, opc[IDX_MSB:IDX_LSB], 1'b0};
   endfunction : table_entry

   assign seq_pc = s.pc + {13'h0000, PC_REQ.length};

   branch_target u_branch (
      .next_pc (seq_pc),
      .disp    (PC_REQ.branch_displacement),
      .target  (rel_pc)
   );

   operand_agen u_operand (
      .req (OP_REQ),
      .res (op_res)
   );

   always_comb begin
      next_s       = s;
      next_s.tread = 1'b0;
      next_s.op    = op_res;
      unique case (s.st)
         ST_RUN: begin
            if (PC_REQ.valid) begin
               unique case (PC_REQ.mode)
                  PC_SEQ:   next_s.pc = seq_pc;
                  PC_REL:   next_s.pc = rel_pc;
                  PC_IMM:   next_s.pc = PC_REQ.absolute_target;
                  PC_PAIR:  next_s.pc = PC_REQ.accum_pair;
                  PC_TABLE: begin
                     next_s.taddr = table_entry(PC_REQ.table_call_instr);
                     next_s.tread = 1'b1;
                     next_s.st    = ST_TBL_LO;
                  end
                  default:  next_s.pc = s.pc;
               endcase
            end
         end
         ST_TBL_LO: begin
            next_s.tlo   = TABLE_DATA;
            next_s.taddr = s.taddr + 16'h0001;
            next_s.tread = 1'b1;
            next_s.st    = ST_TBL_HI;
         end
         ST_TBL_HI: begin
            next_s.pc = {TABLE_DATA, s.tlo};
            next_s.st = ST_RUN;
         end
         default: next_s.st = ST_RUN;
      endcase
      next_s.busy = (next_s.st != ST_RUN);
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         s    <= '0;
         s.pc <= PC_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign PC         = s.pc;
   assign PC_BUSY    = s.busy;
   assign TABLE_READ = s.tread;
   assign TABLE_ADDR = s.taddr;
   assign OP_ADDR    = s.op;

   property p_imm;
      @(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && PC_REQ.valid && PC_REQ.mode == PC_IMM)
         |=> PC == $past(PC_REQ.absolute_target);
   endproperty

   AST_SEQ: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && PC_REQ.valid && PC_REQ.mode == PC_SEQ)
         |=> PC == $past(PC) + 16'($past(PC_REQ.length)))
      else $error("pc did not advance by length");
   AST_REL: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && PC_REQ.valid && PC_REQ.mode == PC_REL)
         |=> PC == $past(PC) + 16'($past(PC_REQ.length))
                 + {{8{$past(PC_REQ.branch_displacement[7])}},
                    $past(PC_REQ.branch_displacement)})
      else $error("relative target wrong");
   AST_IMM: assert property (p_imm)
      else $error("immediate target wrong");
   AST_PAIR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && PC_REQ.valid && PC_REQ.mode == PC_PAIR)
         |=> PC == $past(PC_REQ.accum_pair))
      else $error("pair target wrong");
   AST_TBL: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && PC_REQ.valid && PC_REQ.mode == PC_TABLE)
         |=> TABLE_READ && TABLE_ADDR >= TABLE_BASE && TABLE_ADDR <= TABLE_TOP
             && !TABLE_ADDR[0] ##1 TABLE_READ ##1 PC_BUSY == 1'b0)
      else $error("table walk wrong");
   AST_TBLPC: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_TBL_HI) |=> PC == {$past(TABLE_DATA), $past(TABLE_DATA, 2)})
      else $error("table target bytes wrong");
   AST_DIRECT: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_DIRECT)
         |=> OP_ADDR.addr == $past(OP_REQ.absolute_target))
      else $error("direct address wrong");
   AST_SHORT: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_SHORT)
         |=> OP_ADDR.addr >= 16'hfe20 && OP_ADDR.addr <= 16'hff1f
             && OP_ADDR.addr[7:0] == $past(OP_REQ.field))
      else $error("short address wrong");
   AST_SFR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_SPECIAL && OP_REQ.word) |=> OP_ADDR.error)
      else $error("word special access not flagged");
   AST_REG: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      OP_REQ.valid |=> OP_ADDR.reg_sel == (8'h01 << $past(OP_REQ.reg_field)))
      else $error("register select wrong");

   AST_RST: assert property (@(posedge SYS_CLK)
      !RESETN |=> PC == PC_RESET && !PC_BUSY && !TABLE_READ && !OP_ADDR.valid)
      else $error("reset state wrong");

   AST_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && !PC_REQ.valid) |=> PC == $past(PC))
      else $error("pc moved without request");

   AST_REFUSE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_TBL_LO) |=> PC == $past(PC))
      else $error("pc moved during table walk");

   AST_BUSY: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && PC_REQ.valid && PC_REQ.mode == PC_TABLE)
         |=> PC_BUSY ##1 PC_BUSY ##1 !PC_BUSY)
      else $error("busy window wrong");

   AST_IDLE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && !(PC_REQ.valid && PC_REQ.mode == PC_TABLE)) |=> !PC_BUSY)
      else $error("busy without table call");

   AST_TBL_ADDR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && PC_REQ.valid && PC_REQ.mode == PC_TABLE)
         |=> TABLE_ADDR[5:1] == $past(PC_REQ.table_call_instr[IDX_MSB:IDX_LSB])
             && TABLE_ADDR[15:6] == 10'h001 && !TABLE_ADDR[0])
      else $error("table entry address wrong");

   AST_TBL_NEXT: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_TBL_LO) |=> TABLE_READ && TABLE_ADDR == $past(TABLE_ADDR) + 16'h0001)
      else $error("high byte address wrong");

   AST_TBL_DONE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_TBL_HI) |=> !TABLE_READ && !PC_BUSY)
      else $error("table walk did not end");

   AST_TBL_RANGE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      TABLE_READ |-> TABLE_ADDR >= TABLE_BASE && TABLE_ADDR <= TABLE_TOP)
      else $error("table read outside table");

   AST_REL_BACK: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && PC_REQ.valid && PC_REQ.mode == PC_REL
       && PC_REQ.branch_displacement == 8'hfe && PC_REQ.length == 3'h2)
         |=> PC == $past(PC))
      else $error("negative displacement not sign filled");

   AST_REL_FWD: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (s.st == ST_RUN && PC_REQ.valid && PC_REQ.mode == PC_REL
       && !PC_REQ.branch_displacement[SIGN_BIT])
         |=> PC - $past(PC) == 16'($past(PC_REQ.length))
                 + 16'($past(PC_REQ.branch_displacement)))
      else $error("forward displacement wrong");

   AST_SHORT_HI: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_SHORT && OP_REQ.field < SHORT_SPLIT)
         |=> OP_ADDR.addr[15:8] == SPECIAL_HIGH)
      else $error("short address bit 8 not set");

   AST_SHORT_LO: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_SHORT && OP_REQ.field >= SHORT_SPLIT)
         |=> OP_ADDR.addr[15:8] == SHORT_HIGH)
      else $error("short address bit 8 not clear");

   AST_SHORT_ODD: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_SHORT && OP_REQ.word && OP_REQ.field[0])
         |=> OP_ADDR.error)
      else $error("odd word short address not flagged");

   AST_SHORT_OK: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_SHORT && !(OP_REQ.word && OP_REQ.field[0]))
         |=> !OP_ADDR.error)
      else $error("legal short access flagged");

   AST_SFR_ADDR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_SPECIAL)
         |=> OP_ADDR.addr == {SPECIAL_HIGH, $past(OP_REQ.field)})
      else $error("special register address wrong");

   AST_SFR_LOW: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_SPECIAL && OP_REQ.field <= SPECIAL_LOW_END)
         |=> OP_ADDR.error)
      else $error("low special register not flagged");

   AST_SFR_OK: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_SPECIAL && !OP_REQ.word
       && OP_REQ.field > SPECIAL_LOW_END) |=> !OP_ADDR.error)
      else $error("legal special access flagged");

   AST_WORD: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      OP_REQ.valid |=> OP_ADDR.word == $past(OP_REQ.word))
      else $error("word flag not passed");

   AST_VALID: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      OP_ADDR.valid == $past(OP_REQ.valid))
      else $error("operand valid not one cycle behind");

   AST_NONE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.mode == OP_NONE)
         |=> OP_ADDR.addr == 16'h0000 && !OP_ADDR.error)
      else $error("idle operand mode gave address");

   AST_PAIR_AX: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.pair_operand == PAIR_AX) |=> OP_ADDR.pair_sel == 4'h1)
      else $error("pair zero select wrong");

   AST_PAIR_HL: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.pair_operand == PAIR_HL) |=> OP_ADDR.pair_sel == 4'h8)
      else $error("pair three select wrong");

   AST_REG_X: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.reg_field == REG_X) |=> OP_ADDR.reg_sel == 8'h01)
      else $error("register zero select wrong");

   AST_REG_H: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      (OP_REQ.valid && OP_REQ.reg_field == REG_H) |=> OP_ADDR.reg_sel == 8'h80)
      else $error("register seven select wrong");

   COV_REL: cover property (@(posedge SYS_CLK) s.st == ST_RUN && PC_REQ.valid
      && PC_REQ.mode == PC_REL && PC_REQ.branch_displacement[7]);
   COV_TBL: cover property (@(posedge SYS_CLK) s.st == ST_TBL_HI);
   COV_SHORT: cover property (@(posedge SYS_CLK) OP_REQ.valid
      && OP_REQ.mode == OP_SHORT && OP_REQ.field < 8'h20);
   COV_PAIR: cover property (@(posedge SYS_CLK) s.st == ST_RUN && PC_REQ.valid
      && PC_REQ.mode == PC_PAIR);
   COV_SFR_ERR: cover property (@(posedge SYS_CLK) OP_REQ.valid
      && OP_REQ.mode == OP_SPECIAL && OP_REQ.word);

endmodule : cpu_address_generation

//--- rtl/operand_agen.sv
`timescale 1ns/1ps
module operand_agen
   import agen_pkg::*;
(
   // Request
   input  op_req_t  req,
   // Result
   output op_addr_t res
);

   function automatic logic [15:0] short_addr(input logic [7:0] f);
      short_addr = {SHORT_TOP_BITS, (f < SHORT_SPLIT), f};
   endfunction : short_addr

   always_comb begin
      res         = '0;
      res.valid   = req.valid;
      res.word    = req.word;
      res.reg_sel = 8'h01 << req.reg_field;
      res.pair_sel = 4'h1 << req.pair_operand;
      unique case (req.mode)
         OP_DIRECT: begin
            res.addr = req.absolute_target;
         end
         OP_SHORT: begin
            res.addr  = short_addr(req.field);
            res.error = req.word & req.field[0];
         end
         OP_SPECIAL: begin
            res.addr  = {SPECIAL_HIGH, req.field};
            res.error = req.word | (req.field <= SPECIAL_LOW_END);
         end
         OP_NONE: begin
            res.addr = '0;
         end
      endcase
   end

endmodule : operand_agen

//--- tb/table_mem.sv
`timescale 1ns/1ps
module table_mem (
   // Table port
   input  wire logic        rd,
   input  wire logic [15:0] addr,
   output logic [7:0]       data
);
   logic [7:0] last = 8'h00;
   // Byte pattern, low byte at even address
   always_comb begin
      if (rd) data = addr[7:0] ^ 8'ha5;
      else data = ~last;
   end
   always @(data) if (rd) last = data;
endmodule : table_mem

//--- tb/tb_cpu_address_generation.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_cpu_address_generation
   import agen_pkg::*;
;
   typedef struct {op_mode_t m; logic w; logic [7:0] f; logic [15:0] ea; logic er;} row_t;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        trd, busy;
   logic [15:0] tad, pc, e;
   logic [7:0]  tdat;
   pc_req_t     pq = '0;
   op_req_t     oq = '0;
   op_addr_t    oa;
   int          num_errors = 0;
   int          tests_run = 0;
   int          k;
   row_t rows [12] = '{
      '{OP_DIRECT,  1'b0, 8'h00, 16'h1234, 1'b0},
      '{OP_SHORT,   1'b0, 8'h10, 16'hff10, 1'b0},
      '{OP_SHORT,   1'b0, 8'h00, 16'hff00, 1'b0},
      '{OP_SHORT,   1'b0, 8'h1f, 16'hff1f, 1'b0},
      '{OP_SHORT,   1'b0, 8'h20, 16'hfe20, 1'b0},
      '{OP_SHORT,   1'b0, 8'hff, 16'hfeff, 1'b0},
      '{OP_SHORT,   1'b1, 8'h20, 16'hfe20, 1'b0},
      '{OP_SHORT,   1'b1, 8'h21, 16'hfe21, 1'b1},
      '{OP_SPECIAL, 1'b0, 8'h80, 16'hff80, 1'b0},
      '{OP_SPECIAL, 1'b0, 8'h10, 16'hff10, 1'b1},
      '{OP_SPECIAL, 1'b1, 8'h80, 16'hff80, 1'b1},
      '{OP_NONE,    1'b0, 8'h55, 16'h0000, 1'b0}};

   always #12.5 clk = ~clk;

   cpu_address_generation dut (.SYS_CLK(clk), .RESETN(rstn), .PC_REQ(pq), .OP_REQ(oq),
      .TABLE_DATA(tdat), .TABLE_READ(trd), .TABLE_ADDR(tad), .PC(pc), .PC_BUSY(busy),
      .OP_ADDR(oa));
   table_mem mem (.rd(trd), .addr(tad), .data(tdat));

   task automatic close_out();
      $display("Checks %0d, errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : close_out

   task automatic pc_do(input pc_mode_t m, input logic [2:0] n, input logic [7:0] d,
                        input logic [15:0] a, input logic [7:0] t);
      logic [7:0] b;
      int         w;
      b = {2'h0, t[5:1], 1'b0} + 8'h40;
      pq = '{1'b1, m, n, d, a, t, a};
      case (m)
         PC_SEQ: e = e + 16'(n);
         PC_REL: e = e + 16'(n) + {{8{d[7]}}, d};
         PC_TABLE: e = {(b + 8'h01) ^ 8'ha5, b ^ 8'ha5};
         default: e = a;
      endcase
      @(posedge clk);
      #2;
      w = 0;
      while (busy === 1'b1 && w < 8) begin
         @(posedge clk);
         #2;
         w++;
      end
      `CHK("pc", e, pc)
   endtask : pc_do

   initial begin
      #100000;
      num_errors++;
      close_out();
   end

   initial begin
      repeat (8) @(posedge clk);
      #2;
      rstn = 1'b1;
      `CHK("pc_rst", 16'h0000, pc)
      `CHK("op_rst", op_addr_t'(0), oa)
      `CHK("rd_rst", 1'b0, trd)
      e = 16'h0000;
      for (int i = 1; i <= 4; i++) pc_do(PC_SEQ, 3'(i), 8'h00, 16'h0000, 8'h00);
      pc_do(PC_REL, 3'h2, 8'h80, 16'h0000, 8'h00);
      pc_do(PC_REL, 3'h3, 8'h7f, 16'h0000, 8'h00);
      pc_do(PC_REL, 3'h2, 8'hfe, 16'h0000, 8'h00);
      pc_do(PC_IMM, 3'h3, 8'h00, 16'hc3a5, 8'h00);
      pc_do(PC_PAIR, 3'h1, 8'h00, 16'h1234, 8'h00);
      pc_do(PC_TABLE, 3'h1, 8'h00, 16'h0000, 8'h02);
      pc_do(PC_TABLE, 3'h1, 8'h00, 16'h0000, 8'hc1);
      pq.valid = 1'b0;
      repeat (2) @(posedge clk);
      #2;
      `CHK("pc_hold", e, pc)
      // Last table entry, with a request refused while busy
      pq = '{1'b1, PC_TABLE, 3'h1, 8'h00, 16'h0000, 8'h3e, 16'h0000};
      @(posedge clk);
      #2;
      pq.mode = PC_IMM;
      `CHK("rd", 1'b1, trd)
      `CHK("tad_lo", 16'h007e, tad)
      `CHK("busy", 1'b1, busy)
      @(posedge clk);
      #2;
      `CHK("tad_hi", 16'h007f, tad)
      k = 0;
      while (busy === 1'b1 && k < 8) begin
         @(posedge clk);
         #2;
         k++;
      end
      pq.valid = 1'b0;
      `CHK("pc_tbl", 16'hdadb, pc)
      for (int i = 0; i < 12; i++) begin
         oq = '{1'b1, rows[i].m, rows[i].w, rows[i].ea, rows[i].f, 3'(i), 2'(i)};
         @(posedge clk);
         #2;
         `CHK("op_valid", 1'b1, oa.valid)
         `CHK("op_err", rows[i].er, oa.error)
         if (!rows[i].er) `CHK("op_addr", rows[i].ea, oa.addr)
         `CHK("op_word", rows[i].w, oa.word)
         `CHK("reg_sel", 8'h01 << i[2:0], oa.reg_sel)
         `CHK("pair_sel", 4'h1 << i[1:0], oa.pair_sel)
      end
      oq.valid = 1'b0;
      @(posedge clk);
      #2;
      `CHK("op_idle", 1'b0, oa.valid)
      rstn = 1'b0;
      @(posedge clk);
      #2;
      `CHK("pc_rst2", 16'h0000, pc)
      close_out();
   end
endmodule : tb_cpu_address_generation
